// >>> core/dmbx_exec.sv
`timescale 1ns/100ps
module dmbx_exec #(
    parameter logic [15:0] SP_RESET = 16'h00FF
) (
    // Clock, reset, enable
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    // Decoded operation
    input wire logic I_OP_VALID,
    input wire dmbx_pkg::dmbx_op_t I_OP,
    output logic O_OP_READY,
    // Data memory and stack
    output dmbx_pkg::dmbx_mem_req_t O_MEM,
    input wire logic [7:0] I_MEM_RDATA,
    // I/O registers
    output dmbx_pkg::dmbx_io_req_t O_IO,
    input wire logic [7:0] I_IO_RDATA,
    // System strobes
    output logic O_SLEEP_REQ,
    output logic O_WDOG_CLR,
    // Register port
    input wire logic [5:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA
);

    typedef enum logic {ST_IDLE, ST_EXEC} dmbx_state_t;

    dmbx_state_t st_r;
    logic [1:0] cyc_r;
    dmbx_pkg::dmbx_op_t op_r;
    logic [7:0] regs_r [dmbx_pkg::DMBX_NREGS];
    logic [7:0] status_register_r;
    logic [15:0] sp_r;
    logic [7:0] rdata_r;

    logic first_c;
    logic last_c;
    logic [4:0] ptr_lo;
    logic [4:0] ptr_hi;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_nxt;
    logic [15:0] eff_addr;
    logic [7:0] src;
    logic [7:0] bit_mask;
    logic [7:0] alu_res;
    logic alu_c;
    logic ptr_upd;

    function automatic logic [1:0] op_len(input dmbx_pkg::dmbx_opc_t opc);
        case (opc)
            dmbx_pkg::indirect_load_op, dmbx_pkg::displaced_load_op, dmbx_pkg::direct_load_op,
            dmbx_pkg::indirect_store_op, dmbx_pkg::displaced_store_op, dmbx_pkg::direct_store_op,
            dmbx_pkg::push_op, dmbx_pkg::pop_op,
            dmbx_pkg::io_bit_set_op, dmbx_pkg::io_bit_clear_op: op_len = dmbx_pkg::DMBX_CYC_MEM;
            dmbx_pkg::sleep_op: op_len = dmbx_pkg::DMBX_CYC_SLEEP;
            default: op_len = dmbx_pkg::DMBX_CYC_SINGLE;
        endcase
    endfunction

    function automatic logic is_load(input dmbx_pkg::dmbx_opc_t opc);
        is_load = (opc == dmbx_pkg::indirect_load_op) || (opc == dmbx_pkg::displaced_load_op) ||
                  (opc == dmbx_pkg::direct_load_op) || (opc == dmbx_pkg::pop_op);
    endfunction

    function automatic logic is_store(input dmbx_pkg::dmbx_opc_t opc);
        is_store = (opc == dmbx_pkg::indirect_store_op) || (opc == dmbx_pkg::displaced_store_op) ||
                   (opc == dmbx_pkg::direct_store_op) || (opc == dmbx_pkg::push_op);
    endfunction

    function automatic logic is_io(input dmbx_pkg::dmbx_opc_t opc);
        is_io = (opc == dmbx_pkg::io_bit_set_op) || (opc == dmbx_pkg::io_bit_clear_op);
    endfunction

    assign first_c = (st_r == ST_EXEC) && (cyc_r == dmbx_pkg::DMBX_CYC_FIRST);
    assign last_c = (st_r == ST_EXEC) && (cyc_r == op_len(op_r.opc));
    assign O_OP_READY = (st_r == ST_IDLE);

    // Pointer pair selection
    assign ptr_lo = 5'(dmbx_pkg::DMBX_PTR_BASE + {2'b00, op_r.ptr, 1'b0});
    assign ptr_hi = 5'(ptr_lo + dmbx_pkg::DMBX_ONE5);
    assign ptr_cur = {regs_r[ptr_hi], regs_r[ptr_lo]};
    assign ptr_upd = ((op_r.opc == dmbx_pkg::indirect_load_op) ||
                      (op_r.opc == dmbx_pkg::indirect_store_op)) && (op_r.pmode != dmbx_pkg::PTR_PLAIN);
    assign src = regs_r[op_r.rr];
    assign bit_mask = 8'(dmbx_pkg::DMBX_BIT0 << op_r.bitsel);

    always_comb begin
        ptr_nxt = ptr_cur;
        if (op_r.pmode == dmbx_pkg::PTR_POST_INC) begin
            ptr_nxt = 16'(ptr_cur + dmbx_pkg::DMBX_ONE16);
        end else if (op_r.pmode == dmbx_pkg::PTR_PRE_DEC) begin
            ptr_nxt = 16'(ptr_cur - dmbx_pkg::DMBX_ONE16);
        end
    end

    always_comb begin
        case (op_r.opc)
            dmbx_pkg::indirect_load_op, dmbx_pkg::indirect_store_op: begin
                // Pre-decrement addresses the new value, post-increment the old one
                eff_addr = (op_r.pmode == dmbx_pkg::PTR_PRE_DEC) ? ptr_nxt : ptr_cur;
            end
            dmbx_pkg::displaced_load_op, dmbx_pkg::displaced_store_op: begin
                eff_addr = 16'(ptr_cur + {8'h00, op_r.imm});
            end
            dmbx_pkg::direct_load_op, dmbx_pkg::direct_store_op: begin
                eff_addr = op_r.addr;
            end
            dmbx_pkg::push_op: begin
                eff_addr = sp_r;
            end
            dmbx_pkg::pop_op: begin
                eff_addr = 16'(sp_r + dmbx_pkg::DMBX_ONE16);
            end
            default: begin
                eff_addr = ptr_cur;
            end
        endcase
    end

    // Memory and I/O requests; the I/O write data follows the read data
    // combinationally so set and clear stay within two cycles
    always_comb begin
        O_MEM.addr = eff_addr;
        O_MEM.wdata = src;
        O_MEM.re = first_c && is_load(op_r.opc);
        O_MEM.we = first_c && is_store(op_r.opc);
        O_IO.addr = op_r.imm[5:0];
        O_IO.re = first_c && is_io(op_r.opc);
        O_IO.we = last_c && is_io(op_r.opc);
        if (op_r.opc == dmbx_pkg::io_bit_set_op) begin
            O_IO.wdata = I_IO_RDATA | bit_mask;
        end else begin
            O_IO.wdata = I_IO_RDATA & ~bit_mask;
        end
    end

    assign O_SLEEP_REQ = last_c && (op_r.opc == dmbx_pkg::sleep_op);
    assign O_WDOG_CLR = first_c && (op_r.opc == dmbx_pkg::watchdog_kick_op);

    // Shift and rotate unit
    always_comb begin
        alu_res = regs_r[op_r.rd];
        alu_c = status_register_r[dmbx_pkg::DMBX_FLG_C];
        case (op_r.opc)
            dmbx_pkg::shift_left_op: begin
                alu_res = {regs_r[op_r.rd][6:0], 1'b0};
                alu_c = regs_r[op_r.rd][7];
            end
            dmbx_pkg::rotate_left_carry_op: begin
                alu_res = {regs_r[op_r.rd][6:0], status_register_r[dmbx_pkg::DMBX_FLG_C]};
                alu_c = regs_r[op_r.rd][7];
            end
            dmbx_pkg::shift_right_op: begin
                alu_res = {1'b0, regs_r[op_r.rd][7:1]};
                alu_c = regs_r[op_r.rd][0];
            end
            dmbx_pkg::rotate_right_carry_op: begin
                alu_res = {status_register_r[dmbx_pkg::DMBX_FLG_C], regs_r[op_r.rd][7:1]};
                alu_c = regs_r[op_r.rd][0];
            end
            dmbx_pkg::signed_shift_right_op: begin
                alu_res = {regs_r[op_r.rd][7], regs_r[op_r.rd][7:1]};
                alu_c = regs_r[op_r.rd][0];
            end
            default: begin
                alu_res = regs_r[op_r.rd];
            end
        endcase
    end

    // Sequencer
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_r <= ST_IDLE;
            cyc_r <= dmbx_pkg::DMBX_CYC_FIRST;
            op_r <= '0;
        end else if (I_CE) begin
            case (st_r)
                ST_IDLE: begin
                    if (I_OP_VALID) begin
                        op_r <= I_OP;
                        cyc_r <= dmbx_pkg::DMBX_CYC_FIRST;
                        st_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (last_c) begin
                        st_r <= ST_IDLE;
                    end else begin
                        cyc_r <= 2'(cyc_r + 2'h1);
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Working registers; a port write in the same cycle wins over the core
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < dmbx_pkg::DMBX_NREGS; i++) begin
                regs_r[i] <= dmbx_pkg::DMBX_REG_RST;
            end
        end else if (I_CE) begin
            if (first_c) begin
                case (op_r.opc)
                    dmbx_pkg::reg_copy_op: regs_r[op_r.rd] <= src;
                    dmbx_pkg::immediate_load_op: regs_r[op_r.rd] <= op_r.imm;
                    dmbx_pkg::shift_left_op, dmbx_pkg::rotate_left_carry_op, dmbx_pkg::shift_right_op,
                    dmbx_pkg::rotate_right_carry_op, dmbx_pkg::signed_shift_right_op: begin
                        regs_r[op_r.rd] <= alu_res;
                    end
                    dmbx_pkg::transfer_flag_to_bit_op: begin
                        regs_r[op_r.rd][op_r.bitsel] <= status_register_r[dmbx_pkg::DMBX_FLG_T];
                    end
                    default: begin
                    end
                endcase
                if (ptr_upd) begin
                    regs_r[ptr_lo] <= ptr_nxt[7:0];
                    regs_r[ptr_hi] <= ptr_nxt[15:8];
                end
            end
            if (last_c && is_load(op_r.opc)) begin
                regs_r[op_r.rd] <= I_MEM_RDATA;
            end
            if (I_REG_WR && (I_REG_ADDR < dmbx_pkg::DMBX_BUS_STATUS)) begin
                regs_r[I_REG_ADDR[4:0]] <= I_REG_WDATA;
            end
        end
    end

    // Status register
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            status_register_r <= dmbx_pkg::DMBX_STATUS_RST;
        end else if (I_CE) begin
            if (first_c) begin
                case (op_r.opc)
                    dmbx_pkg::shift_left_op, dmbx_pkg::rotate_left_carry_op, dmbx_pkg::shift_right_op,
                    dmbx_pkg::rotate_right_carry_op, dmbx_pkg::signed_shift_right_op: begin
                        status_register_r[dmbx_pkg::DMBX_FLG_C] <= alu_c;
                        status_register_r[dmbx_pkg::DMBX_FLG_Z] <= (alu_res == dmbx_pkg::DMBX_ZERO8);
                        status_register_r[dmbx_pkg::DMBX_FLG_N] <= alu_res[7];
                        status_register_r[dmbx_pkg::DMBX_FLG_V] <= alu_res[7] ^ alu_c;
                    end
                    dmbx_pkg::bit_to_transfer_flag_op: begin
                        status_register_r[dmbx_pkg::DMBX_FLG_T] <= src[op_r.bitsel];
                    end
                    dmbx_pkg::flag_set_op: status_register_r[op_r.bitsel] <= 1'b1;
                    dmbx_pkg::flag_clear_op: status_register_r[op_r.bitsel] <= 1'b0;
                    dmbx_pkg::irq_enable_op: status_register_r[dmbx_pkg::DMBX_FLG_I] <= 1'b1;
                    dmbx_pkg::irq_disable_op: status_register_r[dmbx_pkg::DMBX_FLG_I] <= 1'b0;
                    default: begin
                    end
                endcase
            end
            if (I_REG_WR && (I_REG_ADDR == dmbx_pkg::DMBX_BUS_STATUS)) begin
                status_register_r <= I_REG_WDATA;
            end
        end
    end

    // Stack pointer: post-decrement on push, pre-increment on pop
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sp_r <= SP_RESET;
        end else if (I_CE) begin
            if (first_c && (op_r.opc == dmbx_pkg::push_op)) begin
                sp_r <= 16'(sp_r - dmbx_pkg::DMBX_ONE16);
            end else if (first_c && (op_r.opc == dmbx_pkg::pop_op)) begin
                sp_r <= 16'(sp_r + dmbx_pkg::DMBX_ONE16);
            end
            if (I_REG_WR && (I_REG_ADDR == dmbx_pkg::DMBX_BUS_SP_LO)) begin
                sp_r[7:0] <= I_REG_WDATA;
            end
            if (I_REG_WR && (I_REG_ADDR == dmbx_pkg::DMBX_BUS_SP_HI)) begin
                sp_r[15:8] <= I_REG_WDATA;
            end
        end
    end

    // Register port read data stands for one cycle only
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdata_r <= dmbx_pkg::DMBX_RDATA_IDLE;
        end else if (I_CE) begin
            if (!I_REG_RD) begin
                rdata_r <= dmbx_pkg::DMBX_RDATA_IDLE;
            end else if (I_REG_ADDR < dmbx_pkg::DMBX_BUS_STATUS) begin
                rdata_r <= regs_r[I_REG_ADDR[4:0]];
            end else if (I_REG_ADDR == dmbx_pkg::DMBX_BUS_STATUS) begin
                rdata_r <= status_register_r;
            end else if (I_REG_ADDR == dmbx_pkg::DMBX_BUS_SP_LO) begin
                rdata_r <= sp_r[7:0];
            end else if (I_REG_ADDR == dmbx_pkg::DMBX_BUS_SP_HI) begin
                rdata_r <= sp_r[15:8];
            end else begin
                rdata_r <= dmbx_pkg::DMBX_RDATA_IDLE;
            end
        end
    end
    assign O_REG_RDATA = rdata_r;

    // Checks
    default clocking dmbx_cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RSTN);

    property p_copy_single;
        (first_c && I_CE && !I_REG_WR && op_r.opc == dmbx_pkg::reg_copy_op)
            |=> (O_OP_READY && regs_r[op_r.rd] == $past(src) && $stable(status_register_r));
    endproperty
    a_copy_single: assert property (p_copy_single) else $error("register copy wrong or slow");

    property p_load_two;
        (first_c && I_CE && op_r.opc == dmbx_pkg::indirect_load_op) |-> O_MEM.re ##1 (last_c && !O_MEM.re);
    endproperty
    a_load_two: assert property (p_load_two) else $error("indirect load not two cycles");

    property p_predec_addr;
        (first_c && is_load(op_r.opc) && op_r.opc == dmbx_pkg::indirect_load_op &&
         op_r.pmode == dmbx_pkg::PTR_PRE_DEC) |-> O_MEM.addr == 16'(ptr_cur - dmbx_pkg::DMBX_ONE16);
    endproperty
    a_predec_addr: assert property (p_predec_addr) else $error("pre-decrement address wrong");

    property p_postinc_ptr;
        (first_c && I_CE && !I_REG_WR && op_r.opc == dmbx_pkg::indirect_store_op &&
         op_r.pmode == dmbx_pkg::PTR_POST_INC) |=> ptr_cur == 16'($past(ptr_cur) + dmbx_pkg::DMBX_ONE16);
    endproperty
    a_postinc_ptr: assert property (p_postinc_ptr) else $error("post-increment pointer wrong");

    property p_load_data;
        (last_c && I_CE && !I_REG_WR && is_load(op_r.opc)) |=> regs_r[op_r.rd] == $past(I_MEM_RDATA);
    endproperty
    a_load_data: assert property (p_load_data) else $error("loaded data not written");

    property p_push_sp;
        (first_c && I_CE && !I_REG_WR && op_r.opc == dmbx_pkg::push_op)
            |-> (O_MEM.we && O_MEM.addr == sp_r) ##1 (sp_r == 16'($past(sp_r) - dmbx_pkg::DMBX_ONE16));
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("push address or stack pointer wrong");

    property p_io_set;
        (last_c && op_r.opc == dmbx_pkg::io_bit_set_op) |-> (O_IO.we && O_IO.wdata == (I_IO_RDATA | bit_mask));
    endproperty
    a_io_set: assert property (p_io_set) else $error("I/O bit set wrong");

    property p_shl_carry;
        (first_c && I_CE && !I_REG_WR && op_r.opc == dmbx_pkg::shift_left_op)
            |=> status_register_r[dmbx_pkg::DMBX_FLG_C] == $past(regs_r[op_r.rd][7]);
    endproperty
    a_shl_carry: assert property (p_shl_carry) else $error("left shift carry wrong");

    property p_sleep_three;
        (first_c && I_CE && op_r.opc == dmbx_pkg::sleep_op) ##1 I_CE |=> (O_SLEEP_REQ && !O_OP_READY);
    endproperty
    a_sleep_three: assert property (p_sleep_three) else $error("sleep not three cycles");

    c_load: cover property (first_c && I_CE && op_r.opc == dmbx_pkg::indirect_load_op);
    c_store: cover property (first_c && I_CE && op_r.opc == dmbx_pkg::displaced_store_op);
    c_io: cover property (O_IO.we && I_CE);
    c_sleep: cover property (O_SLEEP_REQ && I_CE);

endmodule

// >>> include/dmbx_pkg.sv
package dmbx_pkg;

    // Register file and bus map
    localparam int DMBX_NREGS = 32;
    localparam logic [5:0] DMBX_BUS_STATUS = 6'h20;
    localparam logic [5:0] DMBX_BUS_SP_LO = 6'h21;
    localparam logic [5:0] DMBX_BUS_SP_HI = 6'h22;
    localparam logic [7:0] DMBX_STATUS_RST = 8'h00;
    localparam logic [7:0] DMBX_REG_RST = 8'h00;
    localparam logic [7:0] DMBX_RDATA_IDLE = 8'h00;

    // Status bit positions
    localparam int DMBX_FLG_C = 0;
    localparam int DMBX_FLG_Z = 1;
    localparam int DMBX_FLG_N = 2;
    localparam int DMBX_FLG_V = 3;
    localparam int DMBX_FLG_S = 4;
    localparam int DMBX_FLG_H = 5;
    localparam int DMBX_FLG_T = 6;
    localparam int DMBX_FLG_I = 7;

    // Pointer pairs 0 to 2 sit in the top six working registers; pair 3 wraps to registers 0 and 1
    localparam logic [4:0] DMBX_PTR_BASE = 5'h1A;
    localparam logic [4:0] DMBX_ONE5 = 5'h01;
    localparam logic [15:0] DMBX_ONE16 = 16'h0001;
    localparam logic [7:0] DMBX_BIT0 = 8'h01;
    localparam logic [7:0] DMBX_ZERO8 = 8'h00;

    // Execution lengths in cycles
    localparam logic [1:0] DMBX_CYC_FIRST = 2'h1;
    localparam logic [1:0] DMBX_CYC_SINGLE = 2'h1;
    localparam logic [1:0] DMBX_CYC_MEM = 2'h2;
    localparam logic [1:0] DMBX_CYC_SLEEP = 2'h3;

    typedef enum logic [4:0] {
        nop_op,
        reg_copy_op,
        immediate_load_op,
        indirect_load_op,
        displaced_load_op,
        direct_load_op,
        indirect_store_op,
        displaced_store_op,
        direct_store_op,
        push_op,
        pop_op,
        io_bit_set_op,
        io_bit_clear_op,
        shift_left_op,
        shift_right_op,
        rotate_left_carry_op,
        rotate_right_carry_op,
        signed_shift_right_op,
        bit_to_transfer_flag_op,
        transfer_flag_to_bit_op,
        flag_set_op,
        flag_clear_op,
        irq_enable_op,
        irq_disable_op,
        sleep_op,
        watchdog_kick_op
    } dmbx_opc_t;

    typedef enum logic [1:0] {
        PTR_PLAIN,
        PTR_POST_INC,
        PTR_PRE_DEC
    } dmbx_pmode_t;

    typedef struct packed {
        dmbx_opc_t opc;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [7:0] imm;
        logic [15:0] addr;
        logic [1:0] ptr;
        dmbx_pmode_t pmode;
        logic [2:0] bitsel;
    } dmbx_op_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } dmbx_mem_req_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } dmbx_io_req_t;

endpackage

// >>> test/dmbx_exec_bench.sv
`timescale 1ns/100ps
module dmbx_exec_bench;
    logic clk;
    logic rst_n;
    logic ce;
    logic op_valid;
    dmbx_pkg::dmbx_op_t op;
    logic op_ready;
    dmbx_pkg::dmbx_mem_req_t mem;
    dmbx_pkg::dmbx_io_req_t io;
    logic [7:0] mem_rdata;
    logic [7:0] io_rdata;
    logic sleep_req;
    logic wdog_clr;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] cyc;
    logic [7:0] sl;
    logic [7:0] wd;
    int err_count;
    int n_tests;
    localparam logic [5:0] ST = dmbx_pkg::DMBX_BUS_STATUS;
    dmbx_pkg::dmbx_opc_t sop [7] = '{dmbx_pkg::signed_shift_right_op, dmbx_pkg::shift_left_op,
        dmbx_pkg::rotate_left_carry_op, dmbx_pkg::rotate_right_carry_op, dmbx_pkg::shift_right_op,
        dmbx_pkg::rotate_left_carry_op, dmbx_pkg::shift_left_op};
    logic [7:0] sres [7] = '{8'hC0, 8'h80, 8'h01, 8'h80, 8'h40, 8'h80, 8'h00};
    logic [7:0] sst [7] = '{8'h05, 8'h05, 8'h09, 8'h05, 8'h00, 8'h0C, 8'h0B};
    dmbx_exec dut (.I_CORE_CLK(clk), .I_RSTN(rst_n), .I_CE(ce), .I_OP_VALID(op_valid), .I_OP(op),
        .O_OP_READY(op_ready), .O_MEM(mem), .I_MEM_RDATA(mem_rdata), .O_IO(io), .I_IO_RDATA(io_rdata),
        .O_SLEEP_REQ(sleep_req), .O_WDOG_CLR(wdog_clr), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
        .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata));
    dmbx_mem_model mdl (.i_clk(clk), .i_mem(mem), .o_mem_rdata(mem_rdata), .i_io(io), .o_io_rdata(io_rdata));
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // Counts the cycles with ready low and notes in which of them a strobe showed
    task automatic exe(input dmbx_pkg::dmbx_opc_t c, input logic [4:0] r = 5'h00, input logic [7:0] k = 8'h00,
        input logic [2:0] b = 3'h0, input logic [1:0] p = 2'h0, input logic [1:0] m = 2'h0);
        @(posedge clk);
        op_valid <= 1'b1;
        op <= '{c, (c == dmbx_pkg::reg_copy_op) ? r + 5'h01 : r, r, k, {8'h00, k}, p, dmbx_pkg::dmbx_pmode_t'(m), b};
        @(posedge clk);
        op_valid <= 1'b0;
        cyc = 8'h00;
        sl = 8'h00;
        wd = 8'h00;
        #1;
        while (op_ready !== 1'b1 && cyc < 8'h08) begin
            cyc++;
            if (sleep_req === 1'b1) sl = cyc;
            if (wdog_clr === 1'b1) wd = cyc;
            @(posedge clk);
            #1;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #500000;
        err_count++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        op_valid = 1'b0;
        op = '0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(dmbx_pkg::DMBX_BUS_SP_LO, 8'hFF);
        wr(ST, 8'h5A);
        exe(dmbx_pkg::immediate_load_op, 5'h10, 8'hA5);
        chk(cyc, 8'h01);
        exe(dmbx_pkg::reg_copy_op, 5'h10);
        rdc(6'h11, 8'hA5);
        wr(6'h1A, 8'hFF);
        wr(6'h1B, 8'h00);
        exe(dmbx_pkg::indirect_store_op, 5'h10, 8'h00, 3'h0, 2'h0, 2'h1);
        chk(cyc, 8'h02);
        chk(mdl.mem[8'hFF], 8'hA5);
        rdc(6'h1B, 8'h01);
        exe(dmbx_pkg::indirect_load_op, 5'h12, 8'h00, 3'h0, 2'h0, 2'h2);
        chk(cyc, 8'h02);
        rdc(6'h12, 8'hA5);
        rdc(6'h1A, 8'hFF);
        exe(dmbx_pkg::immediate_load_op, 5'h19, 8'h3C);
        exe(dmbx_pkg::push_op, 5'h19);
        chk(cyc, 8'h02);
        chk(mdl.mem[8'hFF], 8'h3C);
        rdc(dmbx_pkg::DMBX_BUS_SP_LO, 8'hFE);
        exe(dmbx_pkg::pop_op, 5'h18);
        chk(cyc, 8'h02);
        rdc(6'h18, 8'h3C);
        wr(6'h1E, 8'h00);
        wr(6'h1F, 8'h02);
        exe(dmbx_pkg::indirect_store_op, 5'h12, 8'h00, 3'h0, 2'h2, 2'h2);
        chk(mdl.mem[8'hFF], 8'hA5);
        rdc(6'h1E, 8'hFF);
        rdc(6'h1F, 8'h01);
        exe(dmbx_pkg::indirect_load_op, 5'h15);
        rdc(6'h15, 8'hA5);
        rdc(6'h1A, 8'hFF);
        wr(6'h1C, 8'h40);
        exe(dmbx_pkg::displaced_store_op, 5'h11, 8'h05, 3'h0, 2'h1);
        chk(mdl.mem[8'h45], 8'hA5);
        exe(dmbx_pkg::displaced_load_op, 5'h13, 8'h05, 3'h0, 2'h1);
        chk(cyc, 8'h02);
        rdc(6'h13, 8'hA5);
        rdc(6'h1C, 8'h40);
        exe(dmbx_pkg::direct_store_op, 5'h10, 8'h33);
        chk(mdl.mem[8'h33], 8'hA5);
        exe(dmbx_pkg::direct_load_op, 5'h17, 8'h33);
        chk(cyc, 8'h02);
        rdc(6'h17, 8'hA5);
        exe(dmbx_pkg::io_bit_set_op, 5'h00, 8'h05, 3'h0);
        exe(dmbx_pkg::io_bit_set_op, 5'h00, 8'h05, 3'h7);
        chk(mdl.io[5], 8'h81);
        exe(dmbx_pkg::io_bit_clear_op, 5'h00, 8'h05, 3'h0);
        chk(cyc, 8'h02);
        chk(mdl.io[5], 8'h80);
        exe(dmbx_pkg::sleep_op);
        chk(cyc, 8'h03);
        chk(sl, 8'h03);
        exe(dmbx_pkg::watchdog_kick_op);
        chk(wd, 8'h01);
        rdc(ST, 8'h5A);
        wr(ST, 8'h00);
        for (int i = 0; i < 8; i++) begin
            exe(dmbx_pkg::flag_set_op, 5'h00, 8'h00, 3'(i));
            rdc(ST, 8'h01 << i);
            exe(dmbx_pkg::flag_clear_op, 5'h00, 8'h00, 3'(i));
            rdc(ST, 8'h00);
        end
        exe(dmbx_pkg::irq_enable_op);
        rdc(ST, 8'h80);
        exe(dmbx_pkg::irq_disable_op);
        rdc(ST, 8'h00);
        wr(6'h14, 8'h81);
        for (int i = 0; i < 7; i++) begin
            exe(sop[i], 5'h14);
            chk(cyc, 8'h01);
            rdc(6'h14, sres[i]);
            rdc(ST, sst[i]);
        end
        wr(6'h15, 8'h10);
        exe(dmbx_pkg::bit_to_transfer_flag_op, 5'h15, 8'h00, 3'h4);
        rdc(ST, 8'h4B);
        exe(dmbx_pkg::transfer_flag_to_bit_op, 5'h16, 8'h00, 3'h2);
        rdc(6'h16, 8'h04);
        // Enable low: the offered operation must not be taken and no register may move
        @(posedge clk);
        ce <= 1'b0;
        exe(dmbx_pkg::immediate_load_op, 5'h16, 8'h77);
        chk(cyc, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        rdc(6'h16, 8'h04);
        rdc(ST, 8'h4B);
        test_done();
    end
endmodule

// >>> test/dmbx_mem_model.sv
`timescale 1ns/100ps
module dmbx_mem_model (
    // Clock
    input wire logic i_clk,
    // Data memory and stack
    input wire dmbx_pkg::dmbx_mem_req_t i_mem,
    output logic [7:0] o_mem_rdata,
    // I/O registers
    input wire dmbx_pkg::dmbx_io_req_t i_io,
    output logic [7:0] o_io_rdata
);
    logic [7:0] mem [256];
    logic [7:0] io [64];
    initial begin
        o_mem_rdata = 8'h00;
        o_io_rdata = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
        for (int i = 0; i < 64; i++) begin
            io[i] = 8'h00;
        end
    end
    // Only low address byte kept; read data toggle when not read so stale data never match
    always @(posedge i_clk) begin
        if (i_mem.we) begin
            mem[i_mem.addr[7:0]] <= i_mem.wdata;
        end
        if (i_io.we) begin
            io[i_io.addr] <= i_io.wdata;
        end
        o_mem_rdata <= i_mem.re ? mem[i_mem.addr[7:0]] : ~o_mem_rdata;
        o_io_rdata <= i_io.re ? io[i_io.addr] : ~o_io_rdata;
    end
endmodule
